// ==== dcir_pkg.sv ====
// Shared constants for the dual-core interrupt routing fabric.
// Assumes one system bus clock and a synchronous, active-high reset.
package dcir_pkg;

   // -----------------------------------------------------------------
   // Source and line counts
   // -----------------------------------------------------------------
   localparam int SRC_CNT     = 174;  // System plus peripheral sources
   localparam int SRC_W       = 8;    // Width of a source index
   localparam int SEC_LINES   = 8;    // Secondary core request lines
   localparam int LINE_W      = 3;    // Width of a line index
   localparam int SEC_SWI     = 8;    // Software-only secondary interrupts
   localparam int MUX_SLOTS   = 4;    // Source slots feeding one line mux
   localparam int SLOT_W      = 2;    // Width of a slot index
   localparam int NMI_SEL     = 4;    // System sources selectable per NMI
   localparam int WAKE_CNT    = 39;   // Sources 0..38 can leave deep sleep
   localparam int IPC_CNT     = 16;   // Inter-processor interrupt structures
   localparam int SYSCALL_REQ = 3;    // Main core, secondary core, debug port

   // -----------------------------------------------------------------
   // Priority layout
   // -----------------------------------------------------------------
   localparam int MAIN_PRIO_W = 3;    // Eight levels, 0 is most urgent
   localparam int SEC_PRIO_W  = 2;    // Four levels, 0 is most urgent
   localparam int SEC_PRIO_N  = 16;   // Eight lines then eight software ones
   localparam int SEC_IDX_W   = 4;

   // -----------------------------------------------------------------
   // Reset values and fixed positions
   // -----------------------------------------------------------------
   localparam logic [MAIN_PRIO_W-1:0] MAIN_PRIO_RST = 3'h7;  // Least urgent
   localparam logic [SEC_PRIO_W-1:0]  SEC_PRIO_RST  = 2'h3;  // Least urgent
   localparam logic [SRC_W:0]         MUX_RST       = 9'h000; // Slot disabled
   localparam logic [LINE_W-1:0]      SYS_LINE      = 3'h0;  // Reserved mux
   localparam logic [SRC_W-1:0]       IPC_SRC_BASE  = 8'h2a; // INTERPROCESSOR_CHANNEL sources

endpackage

// ==== dcir_cfg_table.sv ====
// Small configuration table: one write port, every entry visible at once.
// Assumes the writer is on the same clock; entries are plain flip-flops.
`timescale 1ns/10ps

module dcir_cfg_table #(
   parameter int                ENTRIES = 16,
   parameter int                WIDTH   = 2,
   parameter int                IDX_W   = 4,
   parameter logic [WIDTH-1:0]  RST     = '0
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_reset,
   input  wire logic                       i_we,
   input  wire logic [IDX_W-1:0]           i_idx,
   input  wire logic [WIDTH-1:0]           i_data,
   output logic      [ENTRIES*WIDTH-1:0]   o_table
);

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // Flat output is the register itself, so readers see no extra logic
   logic [ENTRIES*WIDTH-1:0] table_reg;

   // Write one entry; an index past the end is dropped
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         table_reg <= {ENTRIES{RST}};
      end else if (i_we && (int'(i_idx) < ENTRIES)) begin
         table_reg[int'(i_idx)*WIDTH +: WIDTH] <= i_data;
      end
   end

   assign o_table = table_reg;

endmodule

// ==== dcir_router.sv ====
// Interrupt routing fabric feeding a main core and a secondary core.
// Assumes all sources and requests are on i_clk; configuration arrives
// from system logic over plain write ports, there is no software bus.
`timescale 1ns/10ps

module dcir_router (
   input  wire logic                                    i_clk,
   input  wire logic                                    i_reset,
   // Raw interrupt sources
   input  wire logic [dcir_pkg::SRC_CNT-1:0]            i_src,
   // Secondary mux slot writes
   input  wire logic                                    i_mux_we,
   input  wire logic                                    i_mux_sys,
   input  wire logic [dcir_pkg::LINE_W-1:0]             i_mux_line,
   input  wire logic [dcir_pkg::SLOT_W-1:0]             i_mux_slot,
   input  wire logic                                    i_mux_en,
   input  wire logic [dcir_pkg::SRC_W-1:0]              i_mux_src,
   // Priority writes
   input  wire logic                                    i_main_prio_we,
   input  wire logic [dcir_pkg::SRC_W-1:0]              i_main_prio_idx,
   input  wire logic [dcir_pkg::MAIN_PRIO_W-1:0]        i_main_prio_val,
   input  wire logic                                    i_sec_prio_we,
   input  wire logic [dcir_pkg::SEC_IDX_W-1:0]          i_sec_prio_idx,
   input  wire logic [dcir_pkg::SEC_PRIO_W-1:0]         i_sec_prio_val,
   // Current execution priority of each core, top value means idle
   input  wire logic [dcir_pkg::MAIN_PRIO_W:0]          i_main_run_prio,
   input  wire logic [dcir_pkg::SEC_PRIO_W:0]           i_sec_run_prio,
   // Software interrupts of the secondary core
   input  wire logic [dcir_pkg::SEC_SWI-1:0]            i_swi_set,
   input  wire logic [dcir_pkg::SEC_SWI-1:0]            i_swi_clr,
   // NMI source selection
   input  wire logic [dcir_pkg::NMI_SEL*dcir_pkg::SRC_W-1:0] i_main_nmi_src,
   input  wire logic [dcir_pkg::NMI_SEL-1:0]            i_main_nmi_en,
   input  wire logic [dcir_pkg::NMI_SEL*dcir_pkg::SRC_W-1:0] i_sec_nmi_src,
   input  wire logic [dcir_pkg::NMI_SEL-1:0]            i_sec_nmi_en,
   // System call requests and completion
   input  wire logic [dcir_pkg::SYSCALL_REQ-1:0]        i_syscall_req,
   input  wire logic                                    i_syscall_done,
   // Deep sleep state and wake enables
   input  wire logic                                    i_main_deepsleep,
   input  wire logic                                    i_sec_deepsleep,
   input  wire logic [dcir_pkg::WAKE_CNT-1:0]           i_main_wake_en,
   input  wire logic [dcir_pkg::WAKE_CNT-1:0]           i_sec_wake_en,
   // Inter-processor events
   input  wire logic [dcir_pkg::IPC_CNT-1:0]            i_ipc_notify,
   input  wire logic [dcir_pkg::IPC_CNT-1:0]            i_ipc_release,
   input  wire logic [dcir_pkg::IPC_CNT-1:0]            i_ipc_ack,
   // Outputs
   output logic      [dcir_pkg::SRC_CNT-1:0]            o_main_irq,
   output logic      [dcir_pkg::SEC_LINES-1:0]          o_sec_irq,
   output logic      [dcir_pkg::SEC_SWI-1:0]            o_sec_swi,
   output logic                                         o_main_req,
   output logic      [dcir_pkg::SRC_W-1:0]              o_main_id,
   output logic                                         o_sec_req,
   output logic      [dcir_pkg::SEC_IDX_W-1:0]          o_sec_id,
   output logic                                         o_main_nmi,
   output logic                                         o_sec_nmi,
   output logic                                         o_main_wake,
   output logic                                         o_sec_wake,
   output logic      [dcir_pkg::IPC_CNT-1:0]            o_ipc_notify_pend,
   output logic      [dcir_pkg::IPC_CNT-1:0]            o_ipc_release_pend,
   output logic                                         o_mux_refused
);

   // -----------------------------------------------------------------
   // Local sizes and helpers
   // -----------------------------------------------------------------
   localparam int MUX_N   = dcir_pkg::SEC_LINES * dcir_pkg::MUX_SLOTS;
   localparam int MUX_W   = dcir_pkg::SRC_W + 1;  // Enable above index
   localparam int MUX_IW  = dcir_pkg::LINE_W + dcir_pkg::SLOT_W;

   // True when index names an existing source that is pending
   function automatic logic src_hit(input logic [dcir_pkg::SRC_CNT-1:0] v,
                                    input logic [dcir_pkg::SRC_W-1:0]   idx);
      src_hit = (int'(idx) < dcir_pkg::SRC_CNT) ? v[idx] : 1'b0;
   endfunction

   // Any enabled NMI selector pointing at a pending source
   function automatic logic nmi_hit(
      input logic [dcir_pkg::SRC_CNT-1:0]                 v,
      input logic [dcir_pkg::NMI_SEL*dcir_pkg::SRC_W-1:0] sel,
      input logic [dcir_pkg::NMI_SEL-1:0]                 en);
      nmi_hit = 1'b0;
      for (int k = 0; k < dcir_pkg::NMI_SEL; k++) begin
         nmi_hit = nmi_hit | (en[k] & src_hit(v, sel[k*dcir_pkg::SRC_W +: dcir_pkg::SRC_W]));
      end
   endfunction

   // -----------------------------------------------------------------
   // Configuration tables
   // -----------------------------------------------------------------
   logic [MUX_N*MUX_W-1:0]                                mux_tab;     // Line mux slots
   logic [dcir_pkg::SRC_CNT*dcir_pkg::MAIN_PRIO_W-1:0]    main_prio;   // Main levels
   logic [dcir_pkg::SEC_PRIO_N*dcir_pkg::SEC_PRIO_W-1:0]  sec_prio;    // Secondary levels
   logic                                                  mux_wr_ok;   // Write allowed
   logic                                                  mux_wr_bad;  // App hits reserved

   // Only system-privileged writes may touch the reserved mux
   assign mux_wr_bad = i_mux_we && !i_mux_sys && (i_mux_line == dcir_pkg::SYS_LINE);
   assign mux_wr_ok  = i_mux_we && !mux_wr_bad;

   dcir_cfg_table #(
      .ENTRIES (MUX_N),
      .WIDTH   (MUX_W),
      .IDX_W   (MUX_IW),
      .RST     (dcir_pkg::MUX_RST)
   ) u_mux_tab (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_we    (mux_wr_ok),
      .i_idx   ({i_mux_line, i_mux_slot}),
      .i_data  ({i_mux_en, i_mux_src}),
      .o_table (mux_tab)
   );

   dcir_cfg_table #(
      .ENTRIES (dcir_pkg::SRC_CNT),
      .WIDTH   (dcir_pkg::MAIN_PRIO_W),
      .IDX_W   (dcir_pkg::SRC_W),
      .RST     (dcir_pkg::MAIN_PRIO_RST)
   ) u_main_prio (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_we    (i_main_prio_we),
      .i_idx   (i_main_prio_idx),
      .i_data  (i_main_prio_val),
      .o_table (main_prio)
   );

   dcir_cfg_table #(
      .ENTRIES (dcir_pkg::SEC_PRIO_N),
      .WIDTH   (dcir_pkg::SEC_PRIO_W),
      .IDX_W   (dcir_pkg::SEC_IDX_W),
      .RST     (dcir_pkg::SEC_PRIO_RST)
   ) u_sec_prio (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_we    (i_sec_prio_we),
      .i_idx   (i_sec_prio_idx),
      .i_data  (i_sec_prio_val),
      .o_table (sec_prio)
   );

   // -----------------------------------------------------------------
   // Inter-processor structures
   // -----------------------------------------------------------------
   logic [dcir_pkg::IPC_CNT-1:0] notify_reg;   // Notify seen, not yet acked
   logic [dcir_pkg::IPC_CNT-1:0] release_reg;  // Release seen, not yet acked

   // Sticky per structure; a new event beats an ack in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         notify_reg  <= '0;
         release_reg <= '0;
      end else begin
         notify_reg  <= (notify_reg & ~i_ipc_ack) | i_ipc_notify;
         release_reg <= (release_reg & ~i_ipc_ack) | i_ipc_release;
      end
   end

   // -----------------------------------------------------------------
   // Combined source vector
   // -----------------------------------------------------------------
   logic [dcir_pkg::SRC_CNT-1:0] src_all;  // Pins plus INTERPROCESSOR_CHANNEL events

   // INTERPROCESSOR_CHANNEL structures share source slots so either core can take them
   always_comb begin
      src_all = i_src;
      for (int k = 0; k < dcir_pkg::IPC_CNT; k++) begin
         src_all[int'(dcir_pkg::IPC_SRC_BASE) + k] =
            i_src[int'(dcir_pkg::IPC_SRC_BASE) + k] | notify_reg[k] | release_reg[k];
      end
   end

   // -----------------------------------------------------------------
   // Request lines
   // -----------------------------------------------------------------
   logic [dcir_pkg::SEC_LINES-1:0] line_next;  // OR of mapped slots
   logic [dcir_pkg::SEC_LINES-1:0] line_reg;
   logic [dcir_pkg::SEC_SWI-1:0]   swi_reg;    // Software-only pending
   logic [dcir_pkg::SRC_CNT-1:0]   main_irq_reg;

   // Each line ORs all its enabled slots, so a shared line stays high
   always_comb begin
      line_next = '0;
      for (int n = 0; n < MUX_N; n++) begin
         line_next[n / dcir_pkg::MUX_SLOTS] = line_next[n / dcir_pkg::MUX_SLOTS] |
            (mux_tab[n*MUX_W + dcir_pkg::SRC_W] &
             src_hit(src_all, mux_tab[n*MUX_W +: dcir_pkg::SRC_W]));
      end
   end

   // Identity mapping to the main core, muxed lines to the secondary
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         main_irq_reg <= '0;
         line_reg     <= '0;
      end else begin
         main_irq_reg <= src_all;
         line_reg     <= line_next;
      end
   end

   // Software interrupts; a set in the clearing cycle is kept
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         swi_reg <= '0;
      end else begin
         swi_reg <= (swi_reg & ~i_swi_clr) | i_swi_set;
      end
   end

   // -----------------------------------------------------------------
   // Priority selection per core
   // -----------------------------------------------------------------
   logic                              main_found;  // Any main source pending
   logic [dcir_pkg::MAIN_PRIO_W-1:0]  main_lvl;    // Most urgent level
   logic [dcir_pkg::SRC_W-1:0]        main_best;   // Lowest index at that level
   logic                              sec_found;
   logic [dcir_pkg::SEC_PRIO_W-1:0]   sec_lvl;
   logic [dcir_pkg::SEC_IDX_W-1:0]    sec_best;
   logic [dcir_pkg::SEC_PRIO_N-1:0]   sec_pend;    // Lines then software ones

   // Strictly lower level wins; ties go to the lower index
   always_comb begin
      main_found = 1'b0;
      main_lvl   = dcir_pkg::MAIN_PRIO_RST;
      main_best  = '0;
      for (int i = 0; i < dcir_pkg::SRC_CNT; i++) begin
         if (src_all[i] && (!main_found ||
             main_prio[i*dcir_pkg::MAIN_PRIO_W +: dcir_pkg::MAIN_PRIO_W] < main_lvl)) begin
            main_found = 1'b1;
            main_lvl   = main_prio[i*dcir_pkg::MAIN_PRIO_W +: dcir_pkg::MAIN_PRIO_W];
            main_best  = dcir_pkg::SRC_W'(i);
         end
      end
   end

   // Same search over the sixteen secondary interrupts
   always_comb begin
      sec_pend  = {swi_reg, line_reg};
      sec_found = 1'b0;
      sec_lvl   = dcir_pkg::SEC_PRIO_RST;
      sec_best  = '0;
      for (int i = 0; i < dcir_pkg::SEC_PRIO_N; i++) begin
         if (sec_pend[i] && (!sec_found ||
             sec_prio[i*dcir_pkg::SEC_PRIO_W +: dcir_pkg::SEC_PRIO_W] < sec_lvl)) begin
            sec_found = 1'b1;
            sec_lvl   = sec_prio[i*dcir_pkg::SEC_PRIO_W +: dcir_pkg::SEC_PRIO_W];
            sec_best  = dcir_pkg::SEC_IDX_W'(i);
         end
      end
   end

   logic                             main_req_reg;
   logic [dcir_pkg::SRC_W-1:0]       main_id_reg;
   logic                             sec_req_reg;
   logic [dcir_pkg::SEC_IDX_W-1:0]   sec_id_reg;

   // Request only preempts when more urgent than what the core runs
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         main_req_reg <= 1'b0;
         main_id_reg  <= '0;
         sec_req_reg  <= 1'b0;
         sec_id_reg   <= '0;
      end else begin
         main_req_reg <= main_found && ({1'b0, main_lvl} < i_main_run_prio);
         main_id_reg  <= main_best;
         sec_req_reg  <= sec_found && ({1'b0, sec_lvl} < i_sec_run_prio);
         sec_id_reg   <= sec_best;
      end
   end

   // -----------------------------------------------------------------
   // NMI and system calls
   // -----------------------------------------------------------------
   logic syscall_reg;  // System call waiting for the secondary core
   logic main_nmi_reg;
   logic sec_nmi_reg;

   // Any requester sets it; done clears it unless a new one arrives
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         syscall_reg <= 1'b0;
      end else begin
         syscall_reg <= (syscall_reg & ~i_syscall_done) | (|i_syscall_req);
      end
   end

   // NMI is a level while any selected source is pending; the secondary NMI also follows a pending call
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         main_nmi_reg <= 1'b0;
         sec_nmi_reg  <= 1'b0;
      end else begin
         main_nmi_reg <= nmi_hit(src_all, i_main_nmi_src, i_main_nmi_en);
         sec_nmi_reg  <= nmi_hit(src_all, i_sec_nmi_src, i_sec_nmi_en) |
                         syscall_reg;
      end
   end

   // -----------------------------------------------------------------
   // Wakeup controllers
   // -----------------------------------------------------------------
   logic main_wake_reg;
   logic sec_wake_reg;

   // Sources above the wake range are never looked at in deep sleep
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         main_wake_reg <= 1'b0;
         sec_wake_reg  <= 1'b0;
      end else begin
         main_wake_reg <= i_main_deepsleep &&
                          |(src_all[dcir_pkg::WAKE_CNT-1:0] & i_main_wake_en);
         sec_wake_reg  <= i_sec_deepsleep &&
                          |(src_all[dcir_pkg::WAKE_CNT-1:0] & i_sec_wake_en);
      end
   end

   // -----------------------------------------------------------------
   // Refusal flag
   // -----------------------------------------------------------------
   logic refused_reg;  // One-cycle pulse per refused write

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         refused_reg <= 1'b0;
      end else begin
         refused_reg <= mux_wr_bad;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign o_main_irq         = main_irq_reg;
   assign o_sec_irq          = line_reg;
   assign o_sec_swi          = swi_reg;
   assign o_main_req         = main_req_reg;
   assign o_main_id          = main_id_reg;
   assign o_sec_req          = sec_req_reg;
   assign o_sec_id           = sec_id_reg;
   assign o_main_nmi         = main_nmi_reg;
   assign o_sec_nmi          = sec_nmi_reg;
   assign o_main_wake        = main_wake_reg;
   assign o_sec_wake         = sec_wake_reg;
   assign o_ipc_notify_pend  = notify_reg;
   assign o_ipc_release_pend = release_reg;
   assign o_mux_refused      = refused_reg;

endmodule

// ==== dcir_router_asserts.sv ====
// Checker for the interrupt routing fabric, bound to its top module.
// Assumes one clock domain with a synchronous, active-high reset.
`timescale 1ns/10ps
module dcir_chk (
   input wire logic          i_clk,
   input wire logic          i_reset,
   input wire logic [173:0]  i_src,
   input wire logic          i_mux_we,
   input wire logic          i_mux_sys,
   input wire logic [2:0]    i_mux_line,
   input wire logic [3:0]    i_main_run_prio,
   input wire logic [2:0]    i_sec_run_prio,
   input wire logic [7:0]    i_swi_set,
   input wire logic [7:0]    i_swi_clr,
   input wire logic [2:0]    i_syscall_req,
   input wire logic          i_main_deepsleep,
   input wire logic [38:0]   i_main_wake_en,
   input wire logic [15:0]   i_ipc_notify,
   input wire logic [15:0]   i_ipc_ack,
   input wire logic [173:0]  o_main_irq,
   input wire logic [7:0]    o_sec_swi,
   input wire logic          o_main_req,
   input wire logic          o_sec_req,
   input wire logic          o_sec_nmi,
   input wire logic          o_main_wake,
   input wire logic [15:0]   o_ipc_notify_pend,
   input wire logic          o_mux_refused
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // ---------------------------------------------------------------
   // Sequences and properties
   // ---------------------------------------------------------------
   // App write aimed at the reserved line
   sequence s_app_res; i_mux_we && !i_mux_sys && i_mux_line == 3'h0; endsequence
   sequence s_call; |i_syscall_req; endsequence
   // INTERPROCESSOR_CHANNEL slots 42..57 also carry event flags
   property p_main_irq;
      !$past(i_reset) |-> o_main_irq[41:0] == $past(i_src[41:0])
         && o_main_irq[173:58] == $past(i_src[173:58]);
   endproperty
   property p_refuse; s_app_res |=> o_mux_refused; endproperty
   property p_mux_ok; i_mux_we && (i_mux_sys || i_mux_line != 3'h0) |=> !o_mux_refused; endproperty
   property p_call; s_call |-> ##2 o_sec_nmi; endproperty
   property p_wake; i_main_deepsleep && |(i_main_wake_en & i_src[38:0]) |=> o_main_wake; endproperty
   property p_swi_set; i_swi_set[5] |=> o_sec_swi[5]; endproperty
   property p_swi_clr; i_swi_clr[5] && !i_swi_set[5] |=> !o_sec_swi[5]; endproperty
   property p_ipc_ack; i_ipc_ack[3] && !i_ipc_notify[3] |=> !o_ipc_notify_pend[3]; endproperty
   // Nothing is strictly more urgent than level zero
   property p_main_prio; (i_main_run_prio == 4'h0) [*2] |=> !o_main_req; endproperty
   property p_sec_prio; (i_sec_run_prio == 3'h0) [*2] |=> !o_sec_req; endproperty
   a_main_irq: assert property (p_main_irq) else $error("main line off its source");
   a_refuse: assert property (p_refuse) else $error("reserved write not refused");
   a_mux_ok: assert property (p_mux_ok) else $error("legal write refused");
   a_call: assert property (p_call) else $error("no NMI for system call");
   a_wake: assert property (p_wake) else $error("no wake request");
   a_swi_set: assert property (p_swi_set) else $error("software int not set");
   a_swi_clr: assert property (p_swi_clr) else $error("software int not cleared");
   a_ipc_ack: assert property (p_ipc_ack) else $error("ack left notify pending");
   a_main_prio: assert property (p_main_prio) else $error("main preempts level 0");
   a_sec_prio: assert property (p_sec_prio) else $error("secondary preempts level 0");
endmodule

bind dcir_router dcir_chk chk_u (.*);

// ==== dcir_core_model.sv ====
// Behavioural secondary core: finishes a system call after its NMI.
// Assumes the bench clock and the router's synchronous reset.
`timescale 1ns/10ps
module dcir_core_model (
   input  wire logic  i_clk,
   input  wire logic  i_reset,
   input  wire logic  i_nmi,
   input  wire logic  i_slow,
   output logic       o_done = 1'h0
);
   // Pretend call runtime; slow mode tests a long hold of the NMI
   always begin
      @(negedge i_clk);
      if (!i_reset && i_nmi) begin
         repeat (i_slow ? 9 : 1) @(negedge i_clk);
         o_done = 1'h1;
         @(negedge i_clk);
         o_done = 1'h0;
         // No second completion while the old NMI drains
         while (i_nmi) @(negedge i_clk);
      end
   end
endmodule

// ==== tb_dual_core_interrupt_routing.sv ====
// Self-checking bench for the interrupt routing fabric.
// Assumes the router, its checker and the core model compile first.
`timescale 1ns/10ps
module tb_dual_core_interrupt_routing;
   logic i_clk = 1'h0, i_reset = 1'h1, slow = 1'h0, i_syscall_done, i_mux_en = 1'h1;
   logic i_mux_we = 1'h0, i_mux_sys = 1'h0, i_main_prio_we = 1'h0, i_sec_prio_we = 1'h0;
   logic i_main_deepsleep = 1'h0, i_sec_deepsleep = 1'h0;
   logic [173:0] i_src = 174'h0, o_main_irq;
   logic [2:0] i_mux_line, i_main_prio_val, i_syscall_req = 3'h0, i_sec_run_prio = 3'h4;
   logic [1:0] i_mux_slot, i_sec_prio_val;
   logic [7:0] i_mux_src, i_main_prio_idx, i_swi_set = 8'h0, i_swi_clr = 8'h0;
   logic [3:0] i_sec_prio_idx, i_main_run_prio = 4'h8, i_main_nmi_en = 4'h0, i_sec_nmi_en = 4'h0;
   logic [31:0] i_main_nmi_src = 32'h0c000000, i_sec_nmi_src = 32'h0c000000;
   logic [38:0] i_main_wake_en = 39'h0, i_sec_wake_en = 39'h0;
   logic [15:0] i_ipc_notify = 16'h0, i_ipc_release = 16'h0, i_ipc_ack = 16'h0;
   logic [15:0] o_ipc_notify_pend, o_ipc_release_pend;
   logic [7:0] o_sec_irq, o_sec_swi, o_main_id;
   logic [3:0] o_sec_id;
   logic o_main_req, o_sec_req, o_main_nmi, o_sec_nmi, o_main_wake, o_sec_wake, o_mux_refused;
   int n_fail = 0, total_checks = 0, cycles = 0;
   dcir_router dut_u (.*);
   dcir_core_model core_u (.*, .i_nmi(o_sec_nmi), .i_slow(slow), .o_done(i_syscall_done));
   always #2.5 i_clk = ~i_clk;
   // Hang guard, well above the run length
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic mux_wr(input logic sys, logic [2:0] ln, logic [1:0] sl, logic [7:0] s);
      tick(1);
      {i_mux_we, i_mux_sys, i_mux_line, i_mux_slot, i_mux_src} = {1'h1, sys, ln, sl, s};
      tick(1);
      i_mux_we = 1'h0;
   endtask
   task automatic main_prio(input logic [7:0] idx, logic [2:0] val);
      tick(1);
      {i_main_prio_we, i_main_prio_idx, i_main_prio_val} = {1'h1, idx, val};
      tick(1);
      i_main_prio_we = 1'h0;
   endtask
   // Only sources 0..38 may wake a sleeping core
   function automatic logic f_wake(input logic [173:0] s, input logic [38:0] en, input logic d);
      return d && |(s[38:0] & en);
   endfunction
   initial begin
      int w;
      void'($urandom(32'hc1aa0853));
      tick(12);
      i_reset = 1'h0;
      // Random sources; first two straddle the wake range edge
      for (int k = 0; k < 32; k++) begin
         i_src = 174'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
         if (k < 2) i_src = 174'h1 << (39 - k);
         i_main_wake_en = (k < 2) ? 39'h7fffffffff : 39'({$urandom, $urandom});
         i_main_deepsleep = (k < 2) | 1'($urandom);
         {i_sec_deepsleep, i_sec_wake_en} = ~{i_main_deepsleep, i_main_wake_en};
         tick(1);
         chk(o_main_irq[31:0], i_src[31:0]);
         chk(o_main_irq[173:142], i_src[173:142]);
         chk(o_main_wake, f_wake(i_src, i_main_wake_en, i_main_deepsleep));
         chk(o_sec_wake, f_wake(i_src, i_sec_wake_en, i_sec_deepsleep));
      end
      i_src = 174'h0;
      i_main_deepsleep = 1'h0;
      mux_wr(1'h0, 3'h0, 2'h0, 8'h07);
      chk(o_mux_refused, 1);
      mux_wr(1'h0, 3'h3, 2'h1, 8'h09);
      chk(o_mux_refused, 0);
      mux_wr(1'h0, 3'h3, 2'h2, 8'h14);
      {i_src[9], i_src[7]} = 2'h3;
      tick(3);
      chk(o_sec_irq, 8'h08);
      chk({o_sec_req, o_sec_id}, 5'h13);
      {i_src[20], i_src[9]} = 2'h2;
      tick(3);
      chk(o_sec_irq, 8'h08);
      mux_wr(1'h1, 3'h0, 2'h0, 8'h07);
      tick(3);
      chk(o_sec_irq, 8'h09);
      chk(o_sec_id, 4'h0);
      {i_sec_prio_we, i_sec_prio_idx, i_sec_prio_val} = {1'h1, 4'h3, 2'h0};
      tick(1);
      i_sec_prio_we = 1'h0;
      tick(3);
      chk(o_sec_id, 4'h3);
      i_sec_run_prio = 3'h0;
      tick(3);
      chk(o_sec_req, 0);
      i_sec_run_prio = 3'h4;
      i_src = 174'h0;
      tick(3);
      chk(o_sec_irq, 8'h00);
      // Index 11 outranks 10 only through its level
      main_prio(8'h0a, 3'h5);
      main_prio(8'h0b, 3'h2);
      i_main_run_prio = 4'h4;
      i_src[11:10] = 2'h3;
      tick(3);
      chk({o_main_req, o_main_id}, 9'h10b);
      i_main_run_prio = 4'h2;
      tick(3);
      chk(o_main_req, 0);
      i_main_run_prio = 4'h0;
      tick(3);
      chk(o_main_req, 0);
      i_main_run_prio = 4'h8;
      for (int e = 0; e < 2; e++) begin
         {i_main_nmi_en, i_sec_nmi_en} = e ? 8'h87 : 8'h78;
         i_src[12] = 1'h1;
         tick(2);
         chk(o_main_nmi, e);
         chk(o_sec_nmi, !e);
         i_src[12] = 1'h0;
         tick(2);
      end
      {i_swi_set, i_swi_clr} = 16'h6040;
      tick(1);
      i_swi_set = 8'h00;
      chk(o_sec_swi, 8'h60);
      i_swi_clr = 8'h20;
      tick(1);
      i_swi_clr = 8'h00;
      chk(o_sec_swi, 8'h40);
      for (int r = 0; r < 3; r++) begin
         slow = r[0];
         i_syscall_req = 3'(1 << r);
         tick(1);
         i_syscall_req = 3'h0;
         tick(1);
         chk(o_sec_nmi, 1);
         for (w = 0; w < 20 && o_sec_nmi; w++) tick(1);
         chk(o_sec_nmi, 0);
      end
      {i_ipc_notify, i_ipc_release} = 32'h00080010;
      tick(1);
      {i_ipc_notify, i_ipc_release} = 32'h0;
      tick(2);
      chk({o_ipc_notify_pend, o_ipc_release_pend}, 32'h00080010);
      chk(o_main_irq[57:42], 16'h0018);
      i_ipc_ack = 16'h0018;
      tick(1);
      i_ipc_ack = 16'h0;
      tick(2);
      chk({o_ipc_notify_pend, o_ipc_release_pend}, 32'h0);
      wrap_up();
   end
endmodule
